//--- logic/isel_map.vh
`ifndef ISEL_MAP_VH
`define ISEL_MAP_VH
`define MODE_HUB 1'b0
`define MODE_PAR 1'b1
`define MODE_RST 1'b0
`define ST_IDLE 2'h0
`define ST_ARRAY 2'h1
`define ST_STATUS 2'h2
`define ST_ID 2'h3
`define RD_ARRAY 2'h0
`define RD_STATUS 2'h1
`define RD_ID 2'h2
`endif

//--- logic/sync2.v
`timescale 1ns/1ps
// two-stage synchroniser for one level
module sync2 #(
   parameter [0:0] INIT = 1'b0
) (
   input wire clk,
   input wire srst,
   input wire d,
   output reg q
);
   reg meta_q;
   always @(posedge clk) begin
      if (srst) begin
         meta_q <= INIT;
         q <= INIT;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

//--- logic/interface_select_reset.v
`timescale 1ns/1ps
`include "isel_map.vh"
// Operation
// R01 - A low strap selects the hub interface and a high strap the parallel.
// R02 - The host fixes the strap before reset release and never changes it.
// R03 - An unconnected strap reads as low and so selects hub mode.
// R04 - While reset is held every write request is refused in both modes.
// R05 - Reset idles the control machine and releases the four hub lines.
// R06 - Leaving reset the device reads the memory array, not status or id.
// R07 - Either active-low reset input gives exactly the same reset.
// R08 - In hub mode all interface logic runs on the shared bus clock clk.
// R09 - The mode is caught at reset release and held until the next reset.
module interface_select_reset (
   input wire clk,
   input wire srst,
   input wire intf_rst_n,
   input wire cpu_init_n,
   input wire interface_select_strap,
   input wire hub_frame_in,
   input wire [3:0] hub_io_in,
   input wire [3:0] core_io_out,
   input wire core_io_oe,
   input wire wr_req,
   input wire status_cmd,
   input wire id_cmd,
   output reg [3:0] hub_io_out,
   output reg [3:0] hub_io_oe,
   output reg hub_mode,
   output reg par_mode,
   output reg wr_allow,
   output reg core_rst,
   output reg [1:0] read_sel,
   output reg frame_q,
   output reg [3:0] io_in_q
);
   // all logic sits on clk, the shared bus clock in hub mode (see R08)
   wire rst_n_s;
   wire init_n_s;
   wire strap_s;
   wire frame_s;
   wire [3:0] io_s;
   reg in_rst_q;
   reg [1:0] st_q;
   reg [1:0] st_d;
   genvar i;

   // reset pins idle as asserted (low) until synchronised
   sync2 #(.INIT(1'b0)) u_rst (
      .clk(clk), .srst(srst), .d(intf_rst_n), .q(rst_n_s));
   sync2 #(.INIT(1'b0)) u_init (
      .clk(clk), .srst(srst), .d(cpu_init_n), .q(init_n_s));
   // floating strap resolves low at the pad, hub is the reset mode (see R03)
   sync2 #(.INIT(`MODE_RST)) u_strap (
      .clk(clk), .srst(srst), .d(interface_select_strap), .q(strap_s));
   sync2 #(.INIT(1'b0)) u_frame (
      .clk(clk), .srst(srst), .d(hub_frame_in), .q(frame_s));
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_io
         sync2 #(.INIT(1'b0)) u_io (
            .clk(clk), .srst(srst), .d(hub_io_in[i]), .q(io_s[i]));
      end
   endgenerate

   // either input low gives one merged reset (see R07)
   wire any_rst = srst | ~rst_n_s | ~init_n_s;

   function [1:0] sel_of;
      input [1:0] st;
      begin
         case (st)
            `ST_STATUS: sel_of = `RD_STATUS;
            `ST_ID: sel_of = `RD_ID;
            default: sel_of = `RD_ARRAY;
         endcase
      end
   endfunction

   always @* begin
      st_d = st_q;
      case (st_q)
         `ST_IDLE: st_d = `ST_ARRAY; // see R06
         `ST_ARRAY,
         `ST_STATUS,
         `ST_ID: begin
            if (status_cmd)
               st_d = `ST_STATUS;
            else if (id_cmd)
               st_d = `ST_ID;
         end
         default: st_d = `ST_IDLE;
      endcase
   end

   always @(posedge clk) begin
      if (any_rst) begin
         in_rst_q <= 1'b1;
         st_q <= `ST_IDLE; // see R05
         core_rst <= 1'b1;
         wr_allow <= 1'b0; // see R04
         hub_io_oe <= 4'h0; // see R05
         hub_io_out <= 4'h0;
         read_sel <= `RD_ARRAY; // see R06
         frame_q <= 1'b0;
         io_in_q <= 4'h0;
         hub_mode <= hub_mode;
         par_mode <= par_mode;
      end else begin
         in_rst_q <= 1'b0;
         core_rst <= 1'b0;
         st_q <= st_d;
         read_sel <= sel_of(st_d);
         // strap sampled only on the release edge, then frozen (see R09)
         if (in_rst_q) begin
            hub_mode <= (strap_s == `MODE_HUB); // see R01
            par_mode <= (strap_s == `MODE_PAR); // see R01
         end
         // mode not valid on the release edge, so writes wait one cycle
         wr_allow <= ~in_rst_q & wr_req; // see R04
         if (!in_rst_q && hub_mode) begin
            hub_io_oe <= {4{core_io_oe}};
            hub_io_out <= core_io_out;
         end else begin
            hub_io_oe <= 4'h0;
            hub_io_out <= 4'h0;
         end
         frame_q <= frame_s & hub_mode;
         io_in_q <= hub_mode ? io_s : 4'h0;
      end
   end

   // mode flops hold through every reset, srst included; initial value is hub
   initial begin
      hub_mode = 1'b1;
      par_mode = 1'b0;
   end
endmodule

//--- sim/isr_chk.sv
`timescale 1ns/1ps
module isr_chk(
   input wire clk,
   input wire srst,
   input wire intf_rst_n,
   input wire cpu_init_n,
   input wire [3:0] hub_io_oe,
   input wire hub_mode,
   input wire par_mode,
   input wire wr_allow,
   input wire core_rst,
   input wire [1:0] read_sel
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // pins pass a 2-flop sync first
   sequence s_low(x);
      !x [*3];
   endsequence
   chk_mode_pair: assert property (hub_mode != par_mode)
      else $error("mode");
   chk_par_quiet: assert property (par_mode |-> hub_io_oe == 4'h0)
      else $error("par oe");
   chk_wr_block: assert property (core_rst |-> !wr_allow ##1 !wr_allow)
      else $error("wr");
   chk_rst_idle: assert property (core_rst |-> !hub_io_oe && !read_sel)
      else $error("idle");
   chk_rd_array: assert property ($fell(core_rst) |-> read_sel == 2'h0)
      else $error("array");
   chk_init_rst: assert property (s_low(cpu_init_n) |=> core_rst)
      else $error("init");
   chk_pin_rst: assert property (s_low(intf_rst_n) |=> core_rst)
      else $error("rst");
   chk_mode_hold: assert property (!core_rst |=> $stable(hub_mode))
      else $error("hold");
endmodule

//--- sim/hub_host.sv
`timescale 1ns/1ps
module hub_host(
   input wire clk,
   input wire [1:0] strap_sel,
   output wire strap,
   output reg hub_frame_in,
   output reg [3:0] hub_io_in
);
   // strap follows strap_sel at any time, also outside reset; bit 1 floats it
   assign strap = strap_sel[1] ? 1'bz : strap_sel[0];
   initial {hub_frame_in, hub_io_in} = 5'h00;
   always @(negedge clk) begin
      {hub_frame_in, hub_io_in} <= {hub_frame_in, hub_io_in} + 5'h01;
   end
endmodule

//--- sim/interface_select_reset_tb.sv
`timescale 1ns/1ps
module interface_select_reset_tb;
   reg clk = 0, srst = 1, intf_rst_n = 1, cpu_init_n = 1, wr_req = 0;
   reg status_cmd = 0, id_cmd = 0, core_io_oe = 1;
   reg [3:0] core_io_out = 4'h5;
   reg [1:0] strap_sel = 2'h0;
   tri0 interface_select_strap;
   wire hub_frame_in, hub_mode, par_mode, wr_allow, core_rst, frame_q;
   wire [3:0] hub_io_in, hub_io_out, hub_io_oe, io_in_q;
   wire [1:0] read_sel;
   integer mismatches = 0, n_compared = 0;
   hub_host host(.clk(clk), .strap_sel(strap_sel),
      .strap(interface_select_strap), .hub_frame_in(hub_frame_in),
      .hub_io_in(hub_io_in));
   interface_select_reset dut(.*);
   initial forever #2 clk = ~clk;
   task cyc(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task cmp(input [3:0] got, input [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h", $time, got);
      end
   endtask
   task t_mode(input [1:0] s, input e);
      strap_sel = s;
      srst = 1;
      cyc(3);
      srst = 0;
      cyc(6);
      cmp(par_mode, e);
      cmp(hub_io_oe, {4{!e}});
      cmp(read_sel, 4'h0);
      strap_sel = {1'b0, !e};
      cyc(4);
      cmp(par_mode, e);
      $display("mode done");
   endtask
   task t_cmd;
      wr_req = 1;
      status_cmd = 1;
      cyc(1);
      cmp(wr_allow, 4'h1);
      cmp(read_sel, 4'h1);
      status_cmd = 0;
      id_cmd = 1;
      cyc(1);
      id_cmd = 0;
      cmp(read_sel, 4'h2);
      $display("cmd done");
   endtask
   task t_pin(input k);
      if (k)
         cpu_init_n = 0;
      else
         intf_rst_n = 0;
      cyc(4);
      cmp(core_rst, 4'h1);
      cmp(wr_allow, 4'h0);
      cmp(hub_io_oe | read_sel, 4'h0);
      {cpu_init_n, intf_rst_n} = 2'h3;
      cyc(6);
      cmp(read_sel, 4'h0);
      $display("pin done");
   endtask
   task end_sim;
      $display("compared %0d bad %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      cyc(20);
      t_mode(2'h1, 1);
      t_mode(2'h2, 0);
      t_cmd;
      t_pin(0);
      t_cmd;
      t_pin(1);
      end_sim;
   end
   initial begin
      #2000;
      mismatches++;
      end_sim;
   end
endmodule
bind interface_select_reset isr_chk chk(.*);
